// >>> src/umf_params.svh
`ifndef UMF_PARAMS_SVH
`define UMF_PARAMS_SVH

// header layout, byte offsets within a datagram
`define UMF_HDR_SEQ_OFS     0
`define UMF_HDR_KIND_OFS    4
`define UMF_HDR_RSVD_OFS    5
`define UMF_HDR_COUNT_OFS   6
`define UMF_HDR_LEN         8

// last header byte index
`define UMF_HDR_LAST        16'h0007

// measured-values body length in bytes and its last byte index
`define UMF_MV_BODY_LEN     50
`define UMF_MV_LAST         16'h0031

// fragment kind codes
`define UMF_FRAG_LONE       8'h00
`define UMF_FRAG_LEAD       8'h01
`define UMF_FRAG_FOLLOW     8'h02

// body kind codes
`define UMF_BODY_MEAS       8'h00
`define UMF_BODY_Z          8'h01
`define UMF_BODY_INT        8'h02
`define UMF_BODY_ZI         8'h03

// reserved header byte value
`define UMF_RSVD_VAL        8'h00

`endif

// >>> src/umf_pkg.sv
package umf_pkg;

  // framer sequencing states
  typedef enum logic [1:0] {
    UMF_IDLE,
    UMF_HDR,
    UMF_MBODY,
    UMF_PBODY
  } umf_state_e;

endpackage

// >>> src/umf_byte_if.sv
`timescale 1ns/1ps
`default_nettype none

// byte stream between framer and output buffer
interface umf_byte_if;
  logic       valid; // byte offered
  logic       ready; // byte accepted
  logic [7:0] data;  // datagram byte
  logic       last;  // final byte of a datagram
  modport src (output valid, output data, output last, input ready);
  modport snk (input valid, input data, input last, output ready);
endinterface

`default_nettype wire

// >>> src/umf_buf.sv
`timescale 1ns/1ps
`default_nettype none

// two-entry skid buffer, every output from a flop
module umf_buf
  import umf_pkg::*;
#(
  parameter int W = 9
) (
  input  wire logic         clock,
  input  wire logic         rst_b,
  umf_byte_if.snk           in_if,
  output logic [W-1:0]      out_word,
  output logic              out_valid,
  input  wire logic         out_ready
);

  typedef struct packed {
    logic         out_v;  // output entry holds a word
    logic [W-1:0] out_d;  // output entry
    logic         skid_v; // spill entry holds a word
    logic [W-1:0] skid_d; // spill entry
  } umf_buf_s;

  umf_buf_s r_reg;  // registered state
  umf_buf_s r_next; // next state

  logic         push; // word enters
  logic [W-1:0] in_w; // incoming word

  // refuse only while the spill entry is occupied
  assign in_if.ready = ~r_reg.skid_v;
  assign in_w        = {in_if.last, in_if.data};
  assign push        = in_if.valid & ~r_reg.skid_v;
  assign out_word    = r_reg.out_d;
  assign out_valid   = r_reg.out_v;

  // move words forward, spill when the receiver stalls
  always_comb begin
    r_next = r_reg;
    if (!r_reg.out_v || out_ready) begin
      // output slot frees up this cycle
      if (r_reg.skid_v) begin
        r_next.out_d  = r_reg.skid_d;
        r_next.out_v  = 1'b1;
        r_next.skid_v = 1'b0;
      end else if (push) begin
        r_next.out_d = in_w;
        r_next.out_v = 1'b1;
      end else begin
        r_next.out_v = 1'b0;
      end
    end else if (push) begin
      // receiver stalled, park the word
      r_next.skid_d = in_w;
      r_next.skid_v = 1'b1;
    end
  end

  // state register
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

endmodule

`default_nettype wire

// >>> src/umf_framer.sv
// Contract
// - 32-bit block sequence at byte 0, per block
// - fragment kind at byte 4: 0/1/2
// - measured values: always one unfragmented datagram
// - leading fragment carries total datagram count
// - following fragment carries its block position
// - reserved byte 5, body starts at 8
// - first body byte of a lone or leading datagram is body kind
// - measured flags, quality, outputs at bytes 1-7
// - seven floats at body bytes 8-35
// - rate 36, timestamps 40/44, encoder 48
`timescale 1ns/1ps
`default_nettype none
`include "umf_params.svh"

module umf_framer
  import umf_pkg::*;
#(
  parameter int LEN_W     = 16, // width of profile byte count
  parameter int FRAG_BITS = 10  // log2 of body bytes per datagram
) (
  input  wire logic             clock,
  input  wire logic             rst_b,
  // measured-values message
  input  wire logic             mv_valid,
  output logic                  mv_ready,
  input  wire logic             mv_config_mode,
  input  wire logic             mv_time_synced,
  input  wire logic             mv_values_valid,
  input  wire logic             mv_alarm,
  input  wire logic [7:0]       mv_quality,
  input  wire logic             mv_switch_out1,
  input  wire logic             mv_switch_out2,
  input  wire logic [223:0]     mv_values,
  input  wire logic [31:0]      measurement_rate,
  input  wire logic [31:0]      timestamp_seconds,
  input  wire logic [31:0]      timestamp_fraction,
  input  wire logic [15:0]      encoder_position_a,
  // profile block request
  input  wire logic             blk_valid,
  output logic                  blk_ready,
  input  wire logic [7:0]       blk_body_kind,
  input  wire logic [LEN_W-1:0] blk_len,
  // profile body bytes
  input  wire logic             pf_valid,
  output logic                  pf_ready,
  input  wire logic [7:0]       pf_byte,
  // datagram byte stream
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [7:0]            out_data,
  output logic                  out_last,
  // current sequence number
  output logic [31:0]           block_sequence_number
);

  localparam logic [LEN_W:0] PAYLOAD = (LEN_W+1)'(1) << FRAG_BITS; // body bytes per datagram

  // datagram layout as it leaves the framer:
  //   bytes 0-3  block sequence number, low byte first
  //   byte  4    fragment kind: lone, leading or following
  //   byte  5    reserved, always zero
  //   bytes 6-7  fragment total or position, low byte first
  //   bytes 8-   body; in lone and leading datagrams the first byte names the body kind
  // a measured-values message always fits one lone datagram;
  // a profile block is cut into pieces of PAYLOAD body bytes

  typedef struct packed {
    umf_state_e     st;         // sequencing state
    logic [31:0]    seq;        // block sequence number
    logic [15:0]    idx;        // byte index in header or mv body
    logic [LEN_W:0] body_left;  // body bytes left in the block
    logic [LEN_W:0] frag_left;  // body bytes left in this datagram
    logic [LEN_W:0] fetch_left; // profile bytes still to fetch
    logic [15:0]    frag_idx;   // datagram position in block
    logic [15:0]    frag_total; // datagrams in block
    logic [7:0]     kind;       // body kind of block
    logic           kind_due;   // body kind byte not yet sent
    logic [399:0]   mv;         // captured measured-values body
    logic [7:0]     hold;       // fetched profile byte
    logic           hold_v;     // hold holds a byte
    logic           mv_rdy;     // offering to the mv source
    logic           blk_rdy;    // offering to the block source
    logic           pf_rdy;     // fetching profile bytes
  } umf_framer_s;

  umf_framer_s r_reg;  // registered state
  umf_framer_s r_next; // next state

  umf_byte_if bif ();

  logic           e_valid;   // byte offered to buffer
  logic [7:0]     e_data;    // byte offered
  logic           e_last;    // offered byte ends datagram
  logic           push;      // buffer took the byte
  logic [63:0]    hdr_vec;   // header, byte 0 in low bits
  logic [7:0]     frag_kind; // fragment kind of this datagram
  logic [15:0]    frag_word; // fragment total or position
  logic [399:0]   mv_vec;    // measured body, byte 0 in low bits
  logic [LEN_W:0] blk_body;  // block body length incl kind byte
  logic [8:0]     buf_word;  // buffer output word

  // body bytes carried by the next datagram
  // the last piece of a block may be shorter than PAYLOAD
  function automatic logic [LEN_W:0] umf_chunk(input logic [LEN_W:0] left);
    umf_chunk = (left > PAYLOAD) ? PAYLOAD : left;
  endfunction

  // fragment kind and count field of the current datagram:
  // a single datagram carries kind zero and count zero, the
  // leading piece the number of pieces, later pieces their
  // position counted from one
  always_comb begin
    if (r_reg.frag_total <= 16'h0001) begin
      frag_kind = `UMF_FRAG_LONE;
      frag_word = 16'h0000;
    end else if (r_reg.frag_idx == 16'h0000) begin
      frag_kind = `UMF_FRAG_LEAD;
      frag_word = r_reg.frag_total;
    end else begin
      frag_kind = `UMF_FRAG_FOLLOW;
      frag_word = r_reg.frag_idx;
    end
  end

  // header bytes, multi-byte fields low byte first
  // reserved byte is constant zero in every datagram
  assign hdr_vec = {frag_word, `UMF_RSVD_VAL, frag_kind, r_reg.seq};

  // measured-values body, byte 0 in the low bits:
  //   byte 0      body kind, zero for measured values
  //   bytes 1-4   config mode, time synced, values valid, alarm
  //   byte 5      quality
  //   bytes 6-7   switching outputs one and two
  //   bytes 8-35  seven floats, first value in the low word
  //   bytes 36-49 rate, seconds, fraction, encoder position
  // the sources are sampled only on the handshake edge
  assign mv_vec = {encoder_position_a, timestamp_fraction, timestamp_seconds,
                   measurement_rate, mv_values,
                   7'h00, mv_switch_out2, 7'h00, mv_switch_out1, mv_quality,
                   7'h00, mv_alarm, 7'h00, mv_values_valid,
                   7'h00, mv_time_synced, 7'h00, mv_config_mode,
                   `UMF_BODY_MEAS};

  // block body length counts the leading body kind byte
  assign blk_body = {1'b0, blk_len} + (LEN_W+1)'(1);
  assign push     = e_valid & bif.ready;

  // offered byte towards the buffer
  assign bif.valid = e_valid;
  assign bif.data  = e_data;
  assign bif.last  = e_last;

  // sequencing: accept messages, emit header then body
  //   idle  - offer the two sources in alternate cycles
  //   hdr   - eight header bytes, fields from the state
  //   mbody - fifty captured measured-value bytes
  //   pbody - body kind byte, then fetched profile bytes
  // a byte only advances the state when the buffer takes it,
  // so a stall downstream simply freezes the sequencer
  always_comb begin
    r_next  = r_reg;
    e_valid = 1'b0;
    e_data  = 8'h00;
    e_last  = 1'b0;
    // fetch a profile byte into hold
    // hold is a single slot, so fetching pauses until it is sent
    if (pf_valid && r_reg.pf_rdy) begin
      r_next.hold       = pf_byte;
      r_next.hold_v     = 1'b1;
      r_next.fetch_left = r_reg.fetch_left - (LEN_W+1)'(1);
    end
    unique case (r_reg.st)
      UMF_IDLE: begin
        if (mv_valid && r_reg.mv_rdy) begin
          // measured values go out as one lone datagram
          r_next.mv         = mv_vec;
          r_next.kind       = `UMF_BODY_MEAS;
          r_next.frag_total = 16'h0001;
          r_next.frag_idx   = 16'h0000;
          r_next.idx        = 16'h0000;
          r_next.st         = UMF_HDR;
        end else if (blk_valid && r_reg.blk_rdy) begin
          // profile block, split into datagrams of PAYLOAD body bytes
          r_next.kind       = blk_body_kind;
          r_next.kind_due   = 1'b1;
          r_next.body_left  = blk_body;
          r_next.frag_left  = umf_chunk(blk_body);
          r_next.fetch_left = {1'b0, blk_len};
          r_next.frag_total = 16'((({1'b0, blk_body} + (LEN_W+2)'(PAYLOAD))
                                   - (LEN_W+2)'(1)) >> FRAG_BITS);
          r_next.frag_idx   = 16'h0000;
          r_next.idx        = 16'h0000;
          r_next.st         = UMF_HDR;
        end
      end
      UMF_HDR: begin
        // eight header bytes ahead of every body
        e_valid = 1'b1;
        e_data  = hdr_vec[r_reg.idx[2:0]*8 +: 8];
        if (push) begin
          if (r_reg.idx == `UMF_HDR_LAST) begin
            r_next.idx = 16'h0000;
            // body begins at offset eight
            if (r_reg.kind == `UMF_BODY_MEAS && !r_reg.kind_due &&
                r_reg.frag_total == 16'h0001) begin
              // captured measured values follow
              r_next.st = UMF_MBODY;
            end else begin
              // profile body, also for a later piece of a block
              r_next.st = UMF_PBODY;
            end
          end else begin
            r_next.idx = r_reg.idx + 16'h0001;
          end
        end
      end
      UMF_MBODY: begin
        // fixed measured-values body
        e_valid = 1'b1;
        e_data  = r_reg.mv[r_reg.idx*8 +: 8];
        e_last  = (r_reg.idx == `UMF_MV_LAST);
        if (push) begin
          if (e_last) begin
            r_next.st  = UMF_IDLE;
            r_next.seq = r_reg.seq + 32'h0000_0001;
          end else begin
            r_next.idx = r_reg.idx + 16'h0001;
          end
        end
      end
      UMF_PBODY: begin
        // body kind byte first, then fetched profile bytes
        e_valid = r_reg.kind_due | r_reg.hold_v;
        e_data  = r_reg.kind_due ? r_reg.kind : r_reg.hold;
        e_last  = (r_reg.frag_left == (LEN_W+1)'(1));
        if (push) begin
          if (r_reg.kind_due) begin
            r_next.kind_due = 1'b0;
          end else begin
            r_next.hold_v = 1'b0;
          end
          r_next.body_left = r_reg.body_left - (LEN_W+1)'(1);
          r_next.frag_left = r_reg.frag_left - (LEN_W+1)'(1);
          if (e_last) begin
            if (r_reg.body_left == (LEN_W+1)'(1)) begin
              // block done, one number per block
              r_next.st  = UMF_IDLE;
              r_next.seq = r_reg.seq + 32'h0000_0001;
            end else begin
              // next fragment keeps the sequence number
              r_next.frag_idx  = r_reg.frag_idx + 16'h0001;
              r_next.frag_left = umf_chunk(r_reg.body_left - (LEN_W+1)'(1));
              r_next.idx       = 16'h0000;
              r_next.st        = UMF_HDR;
            end
          end
        end
      end
    endcase
    // offer the two sources in turn so only one handshake can occur
    // with no handshake the refused source is offered next cycle; each return to idle offers the mv source first
    r_next.mv_rdy  = (r_next.st == UMF_IDLE) && !r_reg.mv_rdy;
    r_next.blk_rdy = (r_next.st == UMF_IDLE) && r_reg.mv_rdy;
    // fetch while block bytes remain and hold is free
    r_next.pf_rdy  = (r_next.fetch_left != '0) && !r_next.hold_v;
  end

  // state register
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  // output buffer absorbs receiver stalls; it takes a byte
  // while its spill entry is free and presents every word
  // from a flop, so no top output sees the sequencer's logic
  umf_buf #(
    .W (9)
  ) u_buf (
    .clock     (clock),
    .rst_b     (rst_b),
    .in_if     (bif),
    .out_word  (buf_word),
    .out_valid (out_valid),
    .out_ready (out_ready)
  );

  // top outputs, each straight from a register
  assign out_data              = buf_word[7:0];
  assign out_last              = buf_word[8];
  assign mv_ready              = r_reg.mv_rdy;
  assign blk_ready             = r_reg.blk_rdy;
  assign pf_ready              = r_reg.pf_rdy;
  assign block_sequence_number = r_reg.seq;

endmodule

`default_nettype wire

// >>> tb/umf_framer_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// watches the datagram byte stream at the framer's top ports
module umf_framer_chk (
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic        out_valid,
  input  wire logic        out_ready,
  input  wire logic [7:0]  out_data,
  input  wire logic        out_last,
  input  wire logic [31:0] block_sequence_number
);
  logic [15:0] pos_reg;  // index of the byte on offer
  logic [7:0]  kind_reg; // fragment kind of this datagram
  logic [7:0]  bk_reg;   // first body byte of this datagram
  logic [15:0] idx_reg;  // position the current following fragment must carry
  wire         take = out_valid && out_ready; // byte leaves this cycle

  // follow the byte position and remember the header fields on the way
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pos_reg  <= 16'h0000;
      kind_reg <= 8'h00;
      bk_reg   <= 8'h00;
      idx_reg  <= 16'h0000;
    end else if (take) begin
      pos_reg <= out_last ? 16'h0000 : pos_reg + 16'h0001;
      if (pos_reg == 16'h0004) kind_reg <= out_data;
      if (pos_reg == 16'h0008) bk_reg <= out_data;
      // leading fragment restarts the count, each following one steps it
      if (pos_reg == 16'h0004 && out_data == 8'h01) idx_reg <= 16'h0000;
      else if (pos_reg == 16'h0004 && out_data == 8'h02) idx_reg <= idx_reg + 16'h0001;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  property p_seq_step;
    $changed(block_sequence_number) |-> block_sequence_number == $past(block_sequence_number) + 32'h1;
  endproperty
  a_seq_step: assert property (p_seq_step) else $error("sequence jumped");
  property p_kind;
    out_valid && pos_reg == 16'h0004 |-> out_data <= 8'h02;
  endproperty
  a_kind: assert property (p_kind) else $error("bad fragment kind");
  property p_rsvd;
    out_valid && pos_reg == 16'h0005 |-> out_data == 8'h00;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved byte not zero");
  property p_no_short;
    out_valid && out_last |-> pos_reg >= 16'h0008;
  endproperty
  a_no_short: assert property (p_no_short) else $error("datagram without body");
  property p_body_kind;
    out_valid && pos_reg == 16'h0008 && kind_reg != 8'h02 |-> out_data <= 8'h03;
  endproperty
  a_body_kind: assert property (p_body_kind) else $error("bad body kind");
  property p_mv_len;
    out_valid && kind_reg == 8'h00 && bk_reg == 8'h00 && pos_reg > 16'h0008
      |-> out_last == (pos_reg == 16'h0039);
  endproperty
  a_mv_len: assert property (p_mv_len) else $error("measured datagram length");
  property p_flags;
    out_valid && kind_reg == 8'h00 && bk_reg == 8'h00 && pos_reg inside {[16'h0009:16'h000c]}
      |-> out_data <= 8'h01;
  endproperty
  a_flags: assert property (p_flags) else $error("flag byte not boolean");
  property p_follow_pos;
    out_valid && pos_reg == 16'h0006 && kind_reg == 8'h02 |-> out_data == idx_reg[7:0];
  endproperty
  a_follow_pos: assert property (p_follow_pos) else $error("fragment position");
  property p_hold;
    out_valid && !out_ready |=> out_valid && $stable(out_data) && $stable(out_last);
  endproperty
  a_hold: assert property (p_hold) else $error("stalled byte changed");

  c_mv: cover property (take && out_last && kind_reg == 8'h00 && bk_reg == 8'h00);
  c_follow: cover property (take && pos_reg == 16'h0006 && kind_reg == 8'h02);
  c_stall: cover property (out_valid && !out_ready);
endmodule

bind umf_framer umf_framer_chk umf_framer_chk_inst (.clock, .rst_b, .out_valid, .out_ready,
  .out_data, .out_last, .block_sequence_number);
`default_nettype wire

// >>> tb/umf_host.sv
`timescale 1ns/1ps
`default_nettype none
// receiving host: takes datagram bytes, stalling at random, and logs them
module umf_host (
  input  wire logic       clock,
  input  wire logic       rst_b,
  input  wire logic       stall_en,
  input  wire logic       out_valid,
  output logic            out_ready,
  input  wire logic [7:0] out_data,
  input  wire logic       out_last
);
  logic [8:0] got[$];    // received bytes, end-of-datagram flag on top
  int         seed = 15011;

  // ready moves only at the falling edge so it is steady at the sampling edge
  always @(negedge clock) out_ready <= !stall_en || ({$random(seed)} % 3 != 0);
  // every received byte, header and body, kept in arrival order
  always @(posedge clock) if (rst_b && out_valid && out_ready) got.push_back({out_last, out_data});
endmodule
`default_nettype wire

// >>> tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int PL = 4; // body bytes per datagram with two fragment bits
  logic         clock, rst_b, stall_en, mv_valid, mv_ready, blk_valid, blk_ready;
  logic         mv_config_mode, mv_time_synced, mv_values_valid, mv_alarm;
  logic         mv_switch_out1, mv_switch_out2, pf_valid, pf_ready, out_valid, out_ready, out_last;
  logic [7:0]   mv_quality, blk_body_kind, pf_byte, out_data;
  logic [223:0] mv_values;
  logic [31:0]  measurement_rate, timestamp_seconds, timestamp_fraction, block_sequence_number, sq;
  logic [15:0]  encoder_position_a, blk_len;
  logic [8:0]   exp[$];  // expected bytes with end flag
  int           seed, mismatches, compares;

  umf_framer #(.FRAG_BITS(2)) umf_framer_inst (.clock, .rst_b, .mv_valid, .mv_ready,
    .mv_config_mode, .mv_time_synced, .mv_values_valid, .mv_alarm, .mv_quality,
    .mv_switch_out1, .mv_switch_out2, .mv_values, .measurement_rate, .timestamp_seconds,
    .timestamp_fraction, .encoder_position_a, .blk_valid, .blk_ready, .blk_body_kind,
    .blk_len, .pf_valid, .pf_ready, .pf_byte, .out_valid, .out_ready, .out_data, .out_last,
    .block_sequence_number);
  umf_host umf_host_inst (.clock, .rst_b, .stall_en, .out_valid, .out_ready, .out_data,
    .out_last);

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task automatic stop_test;
    if (mismatches == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic cmp_byte(input logic [8:0] e, input logic [8:0] g);
    compares++;
    if (e !== g) begin
      mismatches++;
      $display("unexpected datagram byte: expected %h seen %h", e, g);
    end
  endtask

  task automatic cmp_seq(input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (e !== g) begin
      mismatches++;
      $display("unexpected sequence number: expected %h seen %h", e, g);
    end
  endtask

  function automatic void put(input logic [7:0] b);
    exp.push_back({1'b0, b});
  endfunction

  // header: sequence low byte first, kind, reserved, count
  function automatic void hdr(input logic [7:0] k, input logic [15:0] c);
    for (int i = 0; i < 4; i++) put(sq[8*i +: 8]);
    put(k);
    put(8'h00);
    put(c[7:0]);
    put(c[15:8]);
  endfunction

  function automatic void endg;
    exp[exp.size()-1][8] = 1'b1;
  endfunction

  // wait at falling edges for ready (0 measured, 1 block, 2 byte); next rise takes it
  task automatic go(input int w);
    int n;
    n = 0;
    while (!(w == 0 ? mv_ready : w == 1 ? blk_ready : pf_ready)) begin
      @(negedge clock);
      n++;
      if (n > 500) begin
        mismatches++;
        stop_test();
      end
    end
    @(negedge clock);
  endtask

  task automatic send_mv(input bit c);
    {mv_config_mode, mv_time_synced, mv_values_valid, mv_alarm, mv_switch_out1,
      mv_switch_out2} = c ? 6'h3f : 6'($random(seed));
    mv_quality = c ? 8'hff : 8'($random(seed));
    for (int i = 0; i < 7; i++) mv_values[32*i +: 32] = $random(seed);
    measurement_rate = $random(seed);
    timestamp_seconds = $random(seed);
    timestamp_fraction = c ? 32'hffffffff : $random(seed);
    encoder_position_a = 16'($random(seed));
    hdr(8'h00, 16'h0000);
    put(8'h00);
    put({7'h00, mv_config_mode});
    put({7'h00, mv_time_synced});
    put({7'h00, mv_values_valid});
    put({7'h00, mv_alarm});
    put(mv_quality);
    put({7'h00, mv_switch_out1});
    put({7'h00, mv_switch_out2});
    for (int i = 0; i < 28; i++) put(mv_values[8*i +: 8]);
    for (int i = 0; i < 4; i++) put(measurement_rate[8*i +: 8]);
    for (int i = 0; i < 4; i++) put(timestamp_seconds[8*i +: 8]);
    for (int i = 0; i < 4; i++) put(timestamp_fraction[8*i +: 8]);
    for (int i = 0; i < 2; i++) put(encoder_position_a[8*i +: 8]);
    endg();
    sq++;
    mv_valid = 1'b1;
    go(0);
    mv_valid = 1'b0;
    @(negedge clock);
  endtask

  task automatic send_blk(input logic [7:0] k, input int len);
    logic [7:0] b[$];
    int         n;
    b.push_back(k);
    for (int j = 0; j < len; j++) b.push_back(8'($random(seed)));
    n = (b.size() + PL - 1) / PL;
    for (int i = 0; i < n; i++) begin
      if (n == 1) hdr(8'h00, 16'h0000);
      else hdr(i == 0 ? 8'h01 : 8'h02, 16'(i == 0 ? n : i));
      for (int j = i * PL; j < b.size() && j < (i + 1) * PL; j++) put(b[j]);
      endg();
    end
    sq++;
    blk_body_kind = k;
    blk_len = 16'(len);
    blk_valid = 1'b1;
    go(1);
    blk_valid = 1'b0;
    for (int j = 1; j < b.size(); j++) begin
      pf_byte = b[j];
      pf_valid = 1'b1;
      go(2);
    end
    pf_valid = 1'b0;
    @(negedge clock);
  endtask

  task automatic drain;
    int n;
    n = 0;
    while (umf_host_inst.got.size() < exp.size()) begin
      @(negedge clock);
      n++;
      if (n > 5000) begin
        mismatches++;
        stop_test();
      end
    end
    while (exp.size() > 0) cmp_byte(exp.pop_front(), umf_host_inst.got.pop_front());
    cmp_seq(sq, block_sequence_number);
  endtask

  initial begin
    seed = 15011;
    mismatches = 0;
    compares = 0;
    sq = 32'h0;
    {mv_valid, blk_valid, pf_valid, stall_en, rst_b} = 5'h02;
    {mv_config_mode, mv_time_synced, mv_values_valid, mv_alarm} = 4'h0;
    {mv_switch_out1, mv_switch_out2, mv_quality, blk_body_kind, pf_byte} = 26'h0;
    {mv_values, measurement_rate, timestamp_seconds, timestamp_fraction} = '0;
    {encoder_position_a, blk_len} = 32'h0;
    repeat (10) @(negedge clock);
    rst_b = 1'b1;
    send_mv(1'b1);
    drain();
    for (int k = 1; k < 4; k++) send_blk(8'(k), 3);
    send_blk(8'h01, 4);
    drain();
    repeat (8) begin
      if ($random(seed) & 1) send_mv(1'b0);
      else send_blk(8'(1 + {$random(seed)} % 3), {$random(seed)} % 20);
    end
    drain();
    stall_en = 1'b0;
    send_mv(1'b0);
    send_blk(8'h03, 11);
    drain();
    rst_b = 1'b0;
    repeat (2) @(negedge clock);
    rst_b = 1'b1;
    sq = 32'h0;
    send_mv(1'b0);
    drain();
    stop_test();
  end
endmodule
`default_nettype wire
